// *** design/rfe_ctrl.sv ***
/*
 * Serial programming port and control register bank of the receive front
 * end. Decodes instruction and data bytes from the host, stores settings
 * and drives the receive path control levels from them.
 * Assumes the serial clock half period spans at least four i_clk cycles,
 * and that the auxiliary converter results come from i_clk logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfe_defs.svh"

module rfe_ctrl import rfe_pkg::*; #(
	parameter logic [7:0] REVISION = 8'h00 // Arbitrary value
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Serial programming port
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdio,
	output logic o_sdio,
	output logic o_sdio_oe,
	output logic o_serial_data_out_pin,
	output logic o_serial_data_out_pin_oe,
	// Auxiliary converter results
	input wire logic [9:0] i_aux_a1_data,
	input wire logic [9:0] i_aux_a2_data,
	input wire logic [9:0] i_aux_b1_data,
	input wire logic [9:0] i_aux_b2_data,
	// Serial port setup
	output logic o_three_wire_select,
	output logic o_lsb_first,
	output logic o_pll_relock,
	// Receive power down
	output logic o_pd_ref_diff,
	output logic o_pd_ref,
	output logic o_pd_rx_digital,
	output logic o_pd_chan_b,
	output logic o_pd_chan_a,
	output logic o_pd_buf_b,
	output logic o_pd_buf_a,
	output logic o_pd_all_rx,
	// Receive gain
	output logic o_bypass_buf_a,
	output logic [4:0] o_gain_a,
	output logic o_bypass_buf_b,
	output logic [4:0] o_gain_b,
	// Receive clocking and interface
	output logic o_fast_sampling_duty_optimise,
	output logic o_shared_ref,
	output logic o_duty_stabiliser,
	output logic o_out_tristate,
	output logic o_rx_retime,
	output logic o_twos_complement,
	output logic o_invert_channel_indicator,
	output logic o_mux_out,
	// Auxiliary, sigma-delta and low-rate settings
	output logic [7:0] o_aux_conv_control,
	output logic [7:0] o_aux_conv_clocking,
	output logic [7:0] o_aux_out_a_level,
	output logic [7:0] o_aux_out_b_level,
	output logic [7:0] o_aux_out_c_level,
	output logic [7:0] o_aux_out_update_control,
	output logic [7:0] o_aux_out_power_control,
	output logic [7:0] o_aux_out_invert_control,
	output logic [7:0] o_sigma_delta_word_low,
	output logic [7:0] o_sigma_delta_word_high,
	output logic [7:0] o_low_rate_power_a,
	output logic [7:0] o_low_rate_power_b
);

	// ==========================================================
	// Declarations
	logic [2:0] sclk_sync_reg;
	logic [2:0] cs_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	rfe_state_t state_reg;
	logic [2:0] bit_cnt_reg;
	rfe_byte_t shift_reg;
	rfe_byte_t shift_next;
	logic byte_done;
	logic read_reg;
	logic [`RFE_ADDR_W-1:0] addr_reg;
	logic wr_en_reg;
	logic [`RFE_ADDR_W-1:0] wr_addr_reg;
	rfe_byte_t wr_data_reg;
	logic soft_clear;
	rfe_byte_t mem_rdata;
	rfe_byte_t rd_value;
	rfe_byte_t tx_reg;
	logic tx_loaded_reg;
	logic load_tx;
	logic out_bit_reg;
	logic sdio_oe_reg;
	logic sdo_oe_reg;
	logic relock_reg;
	logic [63:0][7:0] words;

	// ==========================================================
	// Pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg <= 3'h7;
			sdi_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
			cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
			sdi_sync_reg <= {sdi_sync_reg[0], i_sdio};
		end
	end

	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign cs_active = ~cs_sync_reg[1];
	assign shift_next = shift_in(shift_reg, sdi_sync_reg[1], o_lsb_first);
	assign byte_done = sclk_rise && (bit_cnt_reg == `RFE_LAST_BIT);

	// ==========================================================
	// Frame sequencer; deselect aborts any frame in flight
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= RFE_ST_IDLE;
		end else if (!cs_active) begin
			state_reg <= RFE_ST_IDLE;
		end else begin
			case (state_reg)
				RFE_ST_IDLE: state_reg <= RFE_ST_INSTR;
				RFE_ST_INSTR: if (byte_done) begin
					state_reg <= RFE_ST_DATA;
				end
				RFE_ST_DATA: if (byte_done) begin
					state_reg <= RFE_ST_DONE;
				end
				RFE_ST_DONE: state_reg <= RFE_ST_DONE;
				default: state_reg <= RFE_ST_IDLE;
			endcase
		end
	end

	// Bit counter and receive shifter
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else if (state_reg == RFE_ST_IDLE) begin
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else if (sclk_rise && state_reg != RFE_ST_DONE) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg <= shift_next;
		end
	end

	// Instruction decode: read flag and register address
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			read_reg <= 1'b0;
			addr_reg <= '0;
		end else if (state_reg == RFE_ST_INSTR && byte_done) begin
			read_reg <= shift_next[`RFE_INSTR_READ_BIT];
			addr_reg <= shift_next[`RFE_ADDR_W-1:0];
		end
	end

	// ==========================================================
	// Write strobe, one cycle, with unassigned bits forced low
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_en_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= 8'h00;
		end else begin
			wr_en_reg <= (state_reg == RFE_ST_DATA) && byte_done && !read_reg;
			wr_addr_reg <= addr_reg;
			wr_data_reg <= limit_gain(addr_reg, shift_next) & write_mask(addr_reg);
		end
	end

	// Soft reset clears the whole bank instead of storing, so the bit self-clears
	assign soft_clear = wr_en_reg && (wr_addr_reg == `RFE_SERIAL_PORT_SETUP) &&
		wr_data_reg[`RFE_BIT_SOFT_RESET];

	// Relock request for the clock multiplier
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			relock_reg <= 1'b0;
		end else begin
			relock_reg <= soft_clear;
		end
	end

	rfe_regfile #(
		.DEPTH(64),
		.AW(`RFE_ADDR_W),
		.DW(8)
	) u_regfile (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clear(soft_clear),
		.i_we(wr_en_reg && !soft_clear),
		.i_waddr(wr_addr_reg),
		.i_wdata(wr_data_reg),
		.i_raddr(addr_reg),
		.o_rdata(mem_rdata),
		.o_words(words)
	);

	// ==========================================================
	// Read value: converter results and revision are live, the rest stored
	always_comb begin
		case (addr_reg)
			`RFE_AUX_CONV_A2_LOW: rd_value = {i_aux_a2_data[1:0], 6'h00};
			`RFE_AUX_CONV_A2_HIGH: rd_value = i_aux_a2_data[9:2];
			`RFE_AUX_CONV_A1_LOW: rd_value = {i_aux_a1_data[1:0], 6'h00};
			`RFE_AUX_CONV_A1_HIGH: rd_value = i_aux_a1_data[9:2];
			`RFE_AUX_CONV_B2_LOW: rd_value = {i_aux_b2_data[1:0], 6'h00};
			`RFE_AUX_CONV_B2_HIGH: rd_value = i_aux_b2_data[9:2];
			`RFE_AUX_CONV_B1_LOW: rd_value = {i_aux_b1_data[1:0], 6'h00};
			`RFE_AUX_CONV_B1_HIGH: rd_value = i_aux_b1_data[9:2];
			`RFE_SILICON_REVISION: rd_value = REVISION;
			default: rd_value = mem_rdata;
		endcase
	end

	// Transmit loads on the first falling edge of the data byte
	assign load_tx = (state_reg == RFE_ST_DATA) && read_reg && sclk_fall && !tx_loaded_reg;

	// Transmit shifter: bits change on falling edges for the host to sample on rising
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_reg <= 8'h00;
			tx_loaded_reg <= 1'b0;
			out_bit_reg <= 1'b0;
		end else if (state_reg == RFE_ST_IDLE) begin
			tx_loaded_reg <= 1'b0;
			out_bit_reg <= 1'b0;
		end else if (load_tx) begin
			tx_reg <= shift_out(rd_value, o_lsb_first);
			tx_loaded_reg <= 1'b1;
			out_bit_reg <= first_bit(rd_value, o_lsb_first);
		end else if (tx_loaded_reg && sclk_fall && state_reg == RFE_ST_DATA) begin
			tx_reg <= shift_out(tx_reg, o_lsb_first);
			out_bit_reg <= first_bit(tx_reg, o_lsb_first);
		end
	end

	// Drive either the shared pin or the dedicated output, never both
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sdio_oe_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else if (!cs_active) begin
			sdio_oe_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else if (load_tx) begin
			sdio_oe_reg <= o_three_wire_select;
			sdo_oe_reg <= !o_three_wire_select;
		end
	end

	// ==========================================================
	// Outputs, all taken from flip-flops
	assign o_sdio = out_bit_reg;
	assign o_sdio_oe = sdio_oe_reg;
	assign o_serial_data_out_pin = out_bit_reg;
	assign o_serial_data_out_pin_oe = sdo_oe_reg;
	assign o_pll_relock = relock_reg;

	// Serial setup
	assign o_three_wire_select = words[`RFE_SERIAL_PORT_SETUP][`RFE_BIT_THREE_WIRE];
	assign o_lsb_first = words[`RFE_SERIAL_PORT_SETUP][`RFE_BIT_LSB_FIRST];

	// Power down bits map one to one, top bit first
	assign {o_pd_ref_diff, o_pd_ref, o_pd_rx_digital, o_pd_chan_b, o_pd_chan_a,
		o_pd_buf_b, o_pd_buf_a, o_pd_all_rx} = words[`RFE_RECEIVE_POWER_DOWN];

	// Channel gain and buffer bypass
	assign o_bypass_buf_a = words[`RFE_RECEIVE_CHANNEL_A_GAIN][`RFE_BIT_BYPASS];
	assign o_gain_a = words[`RFE_RECEIVE_CHANNEL_A_GAIN][`RFE_GAIN_HI:0];
	assign o_bypass_buf_b = words[`RFE_RECEIVE_CHANNEL_B_GAIN][`RFE_BIT_BYPASS];
	assign o_gain_b = words[`RFE_RECEIVE_CHANNEL_B_GAIN][`RFE_GAIN_HI:0];

	// Clocking and output interface
	assign o_fast_sampling_duty_optimise = words[`RFE_RECEIVE_MISCELLANEOUS][`RFE_BIT_FAST_DUTY];
	assign o_shared_ref = words[`RFE_RECEIVE_MISCELLANEOUS][`RFE_BIT_SHARED_REF];
	assign o_duty_stabiliser = words[`RFE_RECEIVE_MISCELLANEOUS][`RFE_BIT_DUTY_STAB];
	assign o_out_tristate = words[`RFE_RECEIVE_INTERFACE][`RFE_BIT_TRISTATE];
	assign o_rx_retime = words[`RFE_RECEIVE_INTERFACE][`RFE_BIT_RETIME];
	assign o_twos_complement = words[`RFE_RECEIVE_INTERFACE][`RFE_BIT_TWOS];
	assign o_invert_channel_indicator = words[`RFE_RECEIVE_INTERFACE][`RFE_BIT_INV_INDICATOR];
	assign o_mux_out = words[`RFE_RECEIVE_INTERFACE][`RFE_BIT_MUX_OUT];

	// Auxiliary and low-rate settings pass through whole
	assign o_aux_conv_control = words[`RFE_AUX_CONV_CONTROL];
	assign o_aux_conv_clocking = words[`RFE_AUX_CONV_CLOCKING];
	assign o_aux_out_a_level = words[`RFE_AUX_OUT_A_LEVEL];
	assign o_aux_out_b_level = words[`RFE_AUX_OUT_B_LEVEL];
	assign o_aux_out_c_level = words[`RFE_AUX_OUT_C_LEVEL];
	assign o_aux_out_update_control = words[`RFE_AUX_OUT_UPDATE_CONTROL];
	assign o_aux_out_power_control = words[`RFE_AUX_OUT_POWER_CONTROL];
	assign o_aux_out_invert_control = words[`RFE_AUX_OUT_INVERT_CONTROL];
	assign o_sigma_delta_word_low = words[`RFE_SIGMA_DELTA_WORD_LOW];
	assign o_sigma_delta_word_high = words[`RFE_SIGMA_DELTA_WORD_HIGH];
	assign o_low_rate_power_a = words[`RFE_RECEIVE_LOW_RATE_POWER_A];
	assign o_low_rate_power_b = words[`RFE_RECEIVE_LOW_RATE_POWER_B];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	soft_clears_bank_a: assert property (soft_clear |=>
		(words == '0) && o_pll_relock)
		else $error("soft reset did not clear the bank");
	soft_bit_low_a: assert property (
		wr_en_reg |=> !words[`RFE_SERIAL_PORT_SETUP][`RFE_BIT_SOFT_RESET])
		else $error("soft reset bit stayed set");
	relock_single_a: assert property (o_pll_relock |=> !o_pll_relock)
		else $error("relock request longer than one cycle");
	pin_exclusive_a: assert property (o_sdio_oe |->
		o_three_wire_select && !o_serial_data_out_pin_oe)
		else $error("shared pin driven outside three-wire mode");
	dedicated_pin_a: assert property (o_serial_data_out_pin_oe |-> !o_three_wire_select)
		else $error("dedicated output driven in three-wire mode");
	first_bit_order_a: assert property (load_tx |=>
		o_sdio == (o_lsb_first ? $past(rd_value[0]) : $past(rd_value[7])))
		else $error("first read bit in wrong order");
	gain_legal_a: assert property (
		(o_gain_a <= `RFE_GAIN_MAX) && (o_gain_b <= `RFE_GAIN_MAX))
		else $error("gain code above limit");
	power_write_a: assert property (
		wr_en_reg && !soft_clear && wr_addr_reg == `RFE_RECEIVE_POWER_DOWN |=>
		{o_pd_ref_diff, o_pd_chan_a, o_pd_all_rx} ==
		{$past(wr_data_reg[7]), $past(wr_data_reg[3]), $past(wr_data_reg[0])})
		else $error("power down write not applied");
	reserved_zero_a: assert property (
		(words[`RFE_RECEIVE_MISCELLANEOUS][7:3] == 5'h00) &&
		(words[`RFE_RECEIVE_INTERFACE][7:5] == 3'h0) &&
		(words[`RFE_SERIAL_PORT_SETUP][4:0] == 5'h00))
		else $error("unassigned bit holds a one");
	tristate_write_a: assert property (
		wr_en_reg && !soft_clear && wr_addr_reg == `RFE_RECEIVE_INTERFACE |=>
		{o_out_tristate, o_mux_out} == {$past(wr_data_reg[4]), $past(wr_data_reg[0])})
		else $error("interface write not applied");

	write_frame_c: cover property (wr_en_reg && !soft_clear);
	read_three_wire_c: cover property (load_tx && o_three_wire_select);
	read_lsb_first_c: cover property (load_tx && o_lsb_first);
	soft_reset_c: cover property (soft_clear);

endmodule : rfe_ctrl

`default_nettype wire

// *** design/rfe_defs.svh ***
/*
 * Constants of the receive front-end control register bank: register
 * offsets, field positions, write masks, serial frame layout and limits.
 * Assumes inclusion by bare name from the design files of this bank.
 */
`ifndef RFE_DEFS_SVH
`define RFE_DEFS_SVH

// ==========================================================
// Register offsets
`define RFE_ADDR_W 6
`define RFE_SERIAL_PORT_SETUP 6'h00
`define RFE_RECEIVE_POWER_DOWN 6'h01
`define RFE_RECEIVE_CHANNEL_A_GAIN 6'h02
`define RFE_RECEIVE_CHANNEL_B_GAIN 6'h03
`define RFE_RECEIVE_MISCELLANEOUS 6'h04
`define RFE_RECEIVE_INTERFACE 6'h05
`define RFE_AUX_CONV_A2_LOW 6'h1a
`define RFE_AUX_CONV_A2_HIGH 6'h1b
`define RFE_AUX_CONV_A1_LOW 6'h1c
`define RFE_AUX_CONV_A1_HIGH 6'h1d
`define RFE_AUX_CONV_B2_LOW 6'h1e
`define RFE_AUX_CONV_B2_HIGH 6'h1f
`define RFE_AUX_CONV_B1_LOW 6'h20
`define RFE_AUX_CONV_B1_HIGH 6'h21
`define RFE_AUX_CONV_CONTROL 6'h22
`define RFE_AUX_CONV_CLOCKING 6'h23
`define RFE_AUX_OUT_A_LEVEL 6'h24
`define RFE_AUX_OUT_B_LEVEL 6'h25
`define RFE_AUX_OUT_C_LEVEL 6'h26
`define RFE_AUX_OUT_UPDATE_CONTROL 6'h27
`define RFE_AUX_OUT_POWER_CONTROL 6'h28
`define RFE_AUX_OUT_INVERT_CONTROL 6'h29
`define RFE_SIGMA_DELTA_WORD_LOW 6'h2a
`define RFE_SIGMA_DELTA_WORD_HIGH 6'h2b
`define RFE_RECEIVE_LOW_RATE_POWER_A 6'h31
`define RFE_RECEIVE_LOW_RATE_POWER_B 6'h32
`define RFE_SILICON_REVISION 6'h3f

// ==========================================================
// Writable bits per register; everything else stores zero
`define RFE_MASK_SETUP 8'he0
`define RFE_MASK_FULL 8'hff
`define RFE_MASK_GAIN 8'h9f
`define RFE_MASK_MISC 8'h07
`define RFE_MASK_INTERFACE 8'h1f
`define RFE_MASK_CLOCKING 8'h01
`define RFE_MASK_UPDATE 8'h87
`define RFE_MASK_AUX_POWER 8'h07
`define RFE_MASK_INVERT 8'h15
`define RFE_MASK_SIGMA_LOW 8'hf1
`define RFE_MASK_NONE 8'h00
`define RFE_RESET_VALUE 8'h00

// ==========================================================
// Field positions
`define RFE_BIT_THREE_WIRE 7
`define RFE_BIT_LSB_FIRST 6
`define RFE_BIT_SOFT_RESET 5
`define RFE_BIT_BYPASS 7
`define RFE_GAIN_HI 4
`define RFE_GAIN_MAX 5'h14
`define RFE_BIT_FAST_DUTY 2
`define RFE_BIT_SHARED_REF 1
`define RFE_BIT_DUTY_STAB 0
`define RFE_BIT_TRISTATE 4
`define RFE_BIT_RETIME 3
`define RFE_BIT_TWOS 2
`define RFE_BIT_INV_INDICATOR 1
`define RFE_BIT_MUX_OUT 0

// ==========================================================
// Serial frame: instruction byte then one data byte
`define RFE_INSTR_READ_BIT 7
`define RFE_LAST_BIT 3'h7

`endif

// *** design/rfe_pkg.sv ***
/*
 * Types and helper functions shared by the receive front-end control bank.
 * Assumes the constants header is available on the include path.
 */
`include "rfe_defs.svh"

package rfe_pkg;

	// ==========================================================
	// Serial frame sequencer states
	typedef enum logic [1:0] {
		RFE_ST_IDLE = 2'b00,
		RFE_ST_INSTR = 2'b01,
		RFE_ST_DATA = 2'b10,
		RFE_ST_DONE = 2'b11
	} rfe_state_t;

	typedef logic [7:0] rfe_byte_t;

	// ==========================================================
	// Helper functions of the serial sequencer

	// Shift a sampled bit into a byte in the selected order
	function automatic rfe_byte_t shift_in(input rfe_byte_t cur, input logic b,
			input logic lsb);
		return lsb ? {b, cur[7:1]} : {cur[6:0], b};
	endfunction : shift_in

	// Next bit to present from a transmit byte
	function automatic logic first_bit(input rfe_byte_t cur, input logic lsb);
		return lsb ? cur[0] : cur[7];
	endfunction : first_bit

	// Advance a transmit byte by one bit
	function automatic rfe_byte_t shift_out(input rfe_byte_t cur, input logic lsb);
		return lsb ? {1'b0, cur[7:1]} : {cur[6:0], 1'b0};
	endfunction : shift_out

	// Bits that really exist at an address
	function automatic rfe_byte_t write_mask(input logic [`RFE_ADDR_W-1:0] a);
		case (a)
			`RFE_SERIAL_PORT_SETUP: return `RFE_MASK_SETUP;
			`RFE_RECEIVE_POWER_DOWN: return `RFE_MASK_FULL;
			`RFE_RECEIVE_CHANNEL_A_GAIN: return `RFE_MASK_GAIN;
			`RFE_RECEIVE_CHANNEL_B_GAIN: return `RFE_MASK_GAIN;
			`RFE_RECEIVE_MISCELLANEOUS: return `RFE_MASK_MISC;
			`RFE_RECEIVE_INTERFACE: return `RFE_MASK_INTERFACE;
			`RFE_AUX_CONV_CONTROL: return `RFE_MASK_FULL;
			`RFE_AUX_CONV_CLOCKING: return `RFE_MASK_CLOCKING;
			`RFE_AUX_OUT_A_LEVEL: return `RFE_MASK_FULL;
			`RFE_AUX_OUT_B_LEVEL: return `RFE_MASK_FULL;
			`RFE_AUX_OUT_C_LEVEL: return `RFE_MASK_FULL;
			`RFE_AUX_OUT_UPDATE_CONTROL: return `RFE_MASK_UPDATE;
			`RFE_AUX_OUT_POWER_CONTROL: return `RFE_MASK_AUX_POWER;
			`RFE_AUX_OUT_INVERT_CONTROL: return `RFE_MASK_INVERT;
			`RFE_SIGMA_DELTA_WORD_LOW: return `RFE_MASK_SIGMA_LOW;
			`RFE_SIGMA_DELTA_WORD_HIGH: return `RFE_MASK_FULL;
			`RFE_RECEIVE_LOW_RATE_POWER_A: return `RFE_MASK_FULL;
			`RFE_RECEIVE_LOW_RATE_POWER_B: return `RFE_MASK_FULL;
			default: return `RFE_MASK_NONE;
		endcase
	endfunction : write_mask

	// Invalid gain codes saturate at the top legal code
	function automatic rfe_byte_t limit_gain(input logic [`RFE_ADDR_W-1:0] a,
			input rfe_byte_t d);
		rfe_byte_t r;
		r = d;
		if ((a == `RFE_RECEIVE_CHANNEL_A_GAIN || a == `RFE_RECEIVE_CHANNEL_B_GAIN) &&
				d[`RFE_GAIN_HI:0] > `RFE_GAIN_MAX) begin
			r[`RFE_GAIN_HI:0] = `RFE_GAIN_MAX;
		end
		return r;
	endfunction : limit_gain

endpackage : rfe_pkg

// *** design/rfe_regfile.sv ***
/*
 * Register storage for the control bank: a word array with one write port,
 * a registered read port, a whole-bank clear and all words exposed.
 * Assumes writes arrive already masked from the serial sequencer.
 */
`timescale 1ns/1ps
`default_nettype none

module rfe_regfile import rfe_pkg::*; #(
	parameter int DEPTH = 64,
	parameter int AW = 6,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Write side
	input wire logic i_clear,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [DW-1:0] i_wdata,
	// Read side
	input wire logic [AW-1:0] i_raddr,
	output logic [DW-1:0] o_rdata,
	output logic [DEPTH-1:0][DW-1:0] o_words
);

	logic [DEPTH-1:0][DW-1:0] mem_reg;

	// ==========================================================
	// Storage; clear beats a write so a soft reset never half-applies
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_reg <= '0;
		end else if (i_clear) begin
			mem_reg <= '0;
		end else if (i_we) begin
			mem_reg[i_waddr] <= i_wdata;
		end
	end

	// Registered read data
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem_reg[i_raddr];
		end
	end

	assign o_words = mem_reg;

endmodule : rfe_regfile

`default_nettype wire

// *** test/rfe_host.sv ***
/* Host model that drives the serial programming port of the control bank.
   Assumes i_clk is the bank clock and the bench sets the mode bits. */
`timescale 1ns/1ps
`default_nettype none
module rfe_host import rfe_pkg::*; (
	// Clock
	input wire logic i_clk,
	// Data returned by the bank
	input wire logic i_sdio,
	input wire logic i_sdio_oe,
	input wire logic i_sdo,
	input wire logic i_sdo_oe,
	// Serial pins
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sdio
);
	logic three = 1'b0;
	logic lsb = 1'b0;
	logic drv = 1'b0;
	logic rel = 1'b0;
	// ==========
	// Released shared line shows the bank's bit while the bank drives it in three-wire mode, else its inverse, never a stale copy
	assign o_sdio = (three && i_sdio_oe) ? i_sdio : (rel ? ~i_sdio : drv);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
	end
	// One frame: instruction then data byte, sclk phases five clocks each
	task automatic xfer(input logic rd, input logic [5:0] a, input rfe_byte_t d,
			output rfe_byte_t q);
		logic [15:0] w;
		int j;
		w = {rd, 1'b0, a, d};
		q = 8'h00;
		@(posedge i_clk) o_cs_n <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			j = i % 8;
			rel <= rd && i >= 8;
			if (!(rd && i >= 8)) drv <= w[(i < 8 ? 8 : 0) + (lsb ? j : 7 - j)];
			repeat (4) @(posedge i_clk);
			@(negedge i_clk);
			if (i >= 8) q[lsb ? j : 7 - j] = three ? o_sdio : (i_sdo_oe ? i_sdo : ~i_sdo);
			@(posedge i_clk) o_sclk <= 1'b1;
			repeat (5) @(posedge i_clk);
			o_sclk <= 1'b0;
		end
		repeat (5) @(posedge i_clk);
		o_cs_n <= 1'b1;
		rel <= 1'b0;
		repeat (5) @(posedge i_clk);
	endtask : xfer
endmodule : rfe_host
`default_nettype wire

// *** test/rfe_ctrl_tb.sv ***
/* Bench for the control bank: serial frames through the host model.
   Assumes the host model and the bank share one clock. */
`timescale 1ns/1ps
`default_nettype none
module rfe_ctrl_tb import rfe_pkg::*; ;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic sclk, cs_n, sdio, so, so_oe, sd, sd_oe, three, lsb, relock;
	logic [7:0] pd, q, ai;
	logic [5:0] ga, gb;
	logic [2:0] m;
	logic [4:0] f;
	int num_errors = 0;
	int n_tests = 0;
	int n_relock = 0;
	always #2.5 i_clk = ~i_clk;
	rfe_host host (.i_clk(i_clk), .i_sdio(sd), .i_sdio_oe(sd_oe), .i_sdo(so),
		.i_sdo_oe(so_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));
	rfe_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_sdio(sdio), .o_sdio(sd), .o_sdio_oe(sd_oe), .o_serial_data_out_pin(so),
		.o_serial_data_out_pin_oe(so_oe), .i_aux_a1_data(10'h2d6),
		.i_aux_a2_data(10'h000), .i_aux_b1_data(10'h000), .i_aux_b2_data(10'h000),
		.o_three_wire_select(three), .o_lsb_first(lsb), .o_pll_relock(relock),
		.o_pd_ref_diff(pd[7]), .o_pd_ref(pd[6]), .o_pd_rx_digital(pd[5]),
		.o_pd_chan_b(pd[4]), .o_pd_chan_a(pd[3]), .o_pd_buf_b(pd[2]),
		.o_pd_buf_a(pd[1]), .o_pd_all_rx(pd[0]), .o_bypass_buf_a(ga[5]),
		.o_gain_a(ga[4:0]), .o_bypass_buf_b(gb[5]), .o_gain_b(gb[4:0]),
		.o_fast_sampling_duty_optimise(m[2]), .o_shared_ref(m[1]),
		.o_duty_stabiliser(m[0]), .o_out_tristate(f[4]), .o_rx_retime(f[3]),
		.o_twos_complement(f[2]), .o_invert_channel_indicator(f[1]), .o_mux_out(f[0]),
		.o_aux_conv_control(), .o_aux_conv_clocking(), .o_aux_out_a_level(),
		.o_aux_out_b_level(), .o_aux_out_c_level(), .o_aux_out_update_control(),
		.o_aux_out_power_control(), .o_aux_out_invert_control(ai),
		.o_sigma_delta_word_low(), .o_sigma_delta_word_high(),
		.o_low_rate_power_a(), .o_low_rate_power_b());
	// ==========
	// Count clock relock pulses
	always @(posedge i_clk) if (relock === 1'b1) n_relock <= n_relock + 1;
	task automatic chk(input string n, input rfe_byte_t e, input rfe_byte_t g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input rfe_byte_t d);
		host.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [5:0] a, input rfe_byte_t e);
		host.xfer(1'b1, a, 8'h00, q);
		chk("read", e, q);
	endtask : rd
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// ==========
	// Watchdog: the whole sequence needs about 5000 clocks
	initial begin
		#100000;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk);
		for (int a = 0; a < 6; a++) rd(a[5:0], 8'h00);
		wr(6'h01, 8'ha5);
		chk("pd", 8'ha5, pd);
		wr(6'h01, 8'h5a);
		chk("pd", 8'h5a, pd);
		rd(6'h01, 8'h5a);
		wr(6'h02, 8'h9f);
		chk("gain a", 8'h34, {2'b00, ga});
		rd(6'h02, 8'h94);
		wr(6'h03, 8'h14);
		chk("gain b", 8'h14, {2'b00, gb});
		wr(6'h04, 8'h07);
		chk("misc", 8'h07, {5'h00, m});
		rd(6'h04, 8'h07);
		wr(6'h05, 8'h11);
		chk("intf", 8'h11, {3'h0, f});
		wr(6'h05, 8'h01);
		chk("intf", 8'h01, {3'h0, f});
		rd(6'h07, 8'h00);
		rd(6'h1c, 8'h80);
		rd(6'h1d, 8'hb5);
		wr(6'h00, 8'h40);
		host.lsb = 1'b1;
		rd(6'h05, 8'h01);
		wr(6'h00, 8'hc0);
		host.three = 1'b1;
		rd(6'h05, 8'h01);
		chk("mode", 8'h03, {6'h00, three, lsb});
		wr(6'h29, 8'h15);
		chk("aux inv", 8'h15, ai);
		rd(6'h29, 8'h15);
		wr(6'h05, 8'h0e);
		chk("intf", 8'h0e, {3'h0, f});
		wr(6'h00, 8'he0);
		host.three = 1'b0;
		host.lsb = 1'b0;
		chk("relock", 8'h01, n_relock[7:0]);
		rd(6'h00, 8'h00);
		rd(6'h01, 8'h00);
		chk("pd", 8'h00, pd);
		chk("aux inv", 8'h00, ai);
		chk("intf", 8'h00, {3'h0, f});
		end_sim();
	end
endmodule : rfe_ctrl_tb
`default_nettype wire
